// [logic/slmenu_top.sv]
// Status indicator and local menu block with AHB-Lite register slave
// Notes on behaviour
// - Indicator shows most severe enabled condition.
// - Ranking green, yellow, red, flash yellow, flash red.
// - Conditions use allowed levels, selectable when several.
// - Missing input defaults to red.
// - No lock and firmware update default yellow.
// - No module, no rear default flash red.
// - Mismatch and temperature default red.
// - Flash yellow during session or boot.
// - Card select asks for panel session.
// - Select enters edit, second select commits.
// - Escape discards edit, else goes up.
// - Top escape keeps session; card select ends it.
// - Thirty idle seconds end the session.
// - Timeout commits a pending edit.
// - Session starts at status, then parameters.
// - Parameters reset to defined defaults.
// - Per-alarm setting routes alarm to GPI.
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module slmenu_top #(
  parameter longint unsigned TIMEOUT_CYC = slmenu_pkg::TIMEOUT_CYC,
  parameter longint unsigned FLASH_HALF_CYC = slmenu_pkg::FLASH_HALF_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Detected conditions, one bit per condition index
  input wire logic [slmenu_pkg::COND_NUM-1:0] cond_in,
  input wire logic booting,
  // Panel key events, one-cycle pulses from the frame controller link
  input wire logic card_select_btn,
  input wire logic key_plus,
  input wire logic key_minus,
  input wire logic key_select,
  input wire logic key_esc,
  input wire logic param_idx,
  // Outputs
  output logic [2:0] led_rgb_level,
  output logic led_on,
  output logic session_req,
  output logic gpi_alarm,
  output logic opt_tx_on,
  output logic reclock_on
);

  localparam logic [4:0] ALLOW [slmenu_pkg::COND_NUM] = '{
    slmenu_pkg::ALLOW_CFG, slmenu_pkg::ALLOW_FIXED_YELLOW, slmenu_pkg::ALLOW_CFG,
    slmenu_pkg::ALLOW_CFG, slmenu_pkg::ALLOW_FIXED_FRED, slmenu_pkg::ALLOW_CFG,
    slmenu_pkg::ALLOW_FIXED_YELLOW};
  localparam logic [20:0] LEVEL_RESET = {slmenu_pkg::DEF_FW_UPDATE, slmenu_pkg::DEF_TEMP,
    slmenu_pkg::DEF_NO_REAR, slmenu_pkg::DEF_MISMATCH, slmenu_pkg::DEF_NO_MODULE,
    slmenu_pkg::DEF_NO_LOCK, slmenu_pkg::DEF_NO_SIGNAL};

  slmenu_key_if keys ();
  logic session, in_edit, in_params;
  logic [slmenu_pkg::PARAM_W-1:0] params;

  // Route panel keys to the menu engine; panel keys count only in session
  assign keys.card_select = card_select_btn;
  assign keys.key_plus = key_plus && session;
  assign keys.key_minus = key_minus && session;
  assign keys.key_select = key_select && session;
  assign keys.key_esc = key_esc && session;
  assign keys.any_key = session && (key_plus || key_minus || key_select || key_esc);

  slmenu_session #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_session (
    .hclk(hclk),
    .hresetn(hresetn),
    .keys(keys),
    .param_idx(param_idx),
    .session(session),
    .in_edit(in_edit),
    .in_params(in_params),
    .params(params),
    .timed_out()
  );

  // Bus registers
  logic [20:0] lvl_cfg_r, lvl_cfg_nxt;
  logic [slmenu_pkg::COND_NUM-1:0] gpi_cfg_r, gpi_cfg_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic addr_ok;

  assign addr_ok = hsel && hready && htrans[1];

  // Bus next values: capture address phase, write in data phase
  always_comb begin
    lvl_cfg_nxt = lvl_cfg_r;
    gpi_cfg_nxt = gpi_cfg_r;
    wr_pend_nxt = addr_ok && hwrite;
    addr_nxt = addr_ok ? haddr[7:0] : addr_r;
    rdata_nxt = 32'h0;
    if (wr_pend_r) begin
      unique case (addr_r)
        slmenu_pkg::REG_LEVEL_CFG: lvl_cfg_nxt = hwdata[20:0];
        slmenu_pkg::REG_GPI_CFG: gpi_cfg_nxt = hwdata[slmenu_pkg::COND_NUM-1:0];
        default: ;
      endcase
    end
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        slmenu_pkg::REG_LEVEL_CFG: rdata_nxt = {11'h0, lvl_cfg_r};
        slmenu_pkg::REG_GPI_CFG: rdata_nxt = {25'h0, gpi_cfg_r};
        slmenu_pkg::REG_PARAM: rdata_nxt = {30'h0, params};
        slmenu_pkg::REG_STATUS:
          rdata_nxt = {19'h0, cond_in, led_rgb_level, in_params, in_edit, session};
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_cfg_r <= LEVEL_RESET;
      gpi_cfg_r <= '0;
      wr_pend_r <= 1'b0;
      addr_r <= 8'h0;
      rdata_r <= 32'h0;
    end else begin
      lvl_cfg_r <= lvl_cfg_nxt;
      gpi_cfg_r <= gpi_cfg_nxt;
      wr_pend_r <= wr_pend_nxt;
      addr_r <= addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Per-condition level, clamped to allowed set (disallowed selectable code reads as green)
  logic [2:0] cond_lvl [slmenu_pkg::COND_NUM];
  genvar gi;
  generate
    for (gi = 0; gi < slmenu_pkg::COND_NUM; gi++) begin : g_cond
      if (ALLOW[gi] != slmenu_pkg::ALLOW_CFG) begin : g_fixed
        // Single allowed level: the written field is ignored, the default always applies
        assign cond_lvl[gi] = cond_in[gi] ? LEVEL_RESET[3*gi +: 3] : 3'h0;
      end else begin : g_sel
        logic [2:0] cfg;
        logic ok;
        // Selectable level, a disallowed code falls back to green
        assign cfg = lvl_cfg_r[3*gi +: 3];
        assign ok = (cfg <= 3'h4) && ALLOW[gi][cfg];
        assign cond_lvl[gi] = (cond_in[gi] && ok) ? cfg : 3'h0;
      end
    end
  endgenerate

  // Maximum severity over conditions, session and boot
  logic [2:0] worst;
  always_comb begin
    worst = 3'h0;
    for (int i = 0; i < slmenu_pkg::COND_NUM; i++) begin
      if (cond_lvl[i] > worst) begin
        worst = cond_lvl[i];
      end
    end
    if ((session || booting) && worst < 3'(slmenu_pkg::LVL_FLASH_YELLOW)) begin
      worst = 3'(slmenu_pkg::LVL_FLASH_YELLOW);
    end
  end

  // Shared flash timebase
  logic [26:0] fl_cnt_r, fl_cnt_nxt;
  logic phase_r, phase_nxt;
  logic [2:0] led_r, led_nxt;
  logic gpi_r, gpi_nxt;
  logic sreq_r, sreq_nxt;

  always_comb begin
    fl_cnt_nxt = fl_cnt_r + 27'h1;
    phase_nxt = phase_r;
    if (fl_cnt_r == 27'(FLASH_HALF_CYC - 1)) begin
      fl_cnt_nxt = 27'h0;
      phase_nxt = ~phase_r;
    end
    led_nxt = worst;
    gpi_nxt = |(cond_in & gpi_cfg_r);
    sreq_nxt = card_select_btn;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fl_cnt_r <= 27'h0;
      phase_r <= 1'b1;
      led_r <= 3'h0;
      gpi_r <= 1'b0;
      sreq_r <= 1'b0;
    end else begin
      fl_cnt_r <= fl_cnt_nxt;
      phase_r <= phase_nxt;
      led_r <= led_nxt;
      gpi_r <= gpi_nxt;
      sreq_r <= sreq_nxt;
    end
  end

  assign led_rgb_level = led_r;
  assign led_on = (led_r >= 3'h3) ? phase_r : 1'b1;
  assign session_req = sreq_r;
  assign gpi_alarm = gpi_r;
  assign opt_tx_on = params[0];
  assign reclock_on = params[1];

endmodule

// [common/slmenu_pkg.sv]
// Package of constants and types for the status indicator and local menu block
package slmenu_pkg;

  // Indicator levels, ranked least to most severe
  typedef enum logic [2:0] {
    LVL_GREEN  = 3'h0,
    LVL_YELLOW = 3'h1,
    LVL_RED    = 3'h2,
    LVL_FLASH_YELLOW = 3'h3,
    LVL_FLASH_RED    = 3'h4
  } slmenu_level_type;

  // Condition indices
  localparam int unsigned COND_NO_SIGNAL = 0;
  localparam int unsigned COND_NO_LOCK   = 1;
  localparam int unsigned COND_NO_MODULE = 2;
  localparam int unsigned COND_MISMATCH  = 3;
  localparam int unsigned COND_NO_REAR   = 4;
  localparam int unsigned COND_TEMP      = 5;
  localparam int unsigned COND_FW_UPDATE = 6;
  localparam int unsigned COND_NUM       = 7;

  // Allowed level masks per condition, bit n = level n allowed
  localparam logic [4:0] ALLOW_CFG   = 5'h17; // green/yellow/red/flash red
  localparam logic [4:0] ALLOW_FIXED_YELLOW = 5'h02;
  localparam logic [4:0] ALLOW_FIXED_FRED   = 5'h10;

  // Default levels after reset
  localparam logic [2:0] DEF_NO_SIGNAL = 3'h2;
  localparam logic [2:0] DEF_NO_LOCK   = 3'h1;
  localparam logic [2:0] DEF_NO_MODULE = 3'h4;
  localparam logic [2:0] DEF_MISMATCH  = 3'h2;
  localparam logic [2:0] DEF_NO_REAR   = 3'h4;
  localparam logic [2:0] DEF_TEMP      = 3'h2;
  localparam logic [2:0] DEF_FW_UPDATE = 3'h1;

  // Register byte offsets
  localparam logic [7:0] REG_LEVEL_CFG = 8'h00; // 3 bits per condition
  localparam logic [7:0] REG_GPI_CFG   = 8'h04; // 1 bit per condition
  localparam logic [7:0] REG_PARAM     = 8'h08; // menu parameters, edit value while editing
  localparam logic [7:0] REG_STATUS    = 8'h0c; // read-only state

  // Menu parameter bits in REG_PARAM: optical tx on, reclocker on
  localparam int unsigned PARAM_W = 2;
  localparam logic [1:0] PARAM_DEFAULT = 2'h3;

  // Menu session states
  typedef enum logic [1:0] {
    MS_IDLE,
    MS_STATUS,
    MS_PARAM,
    MS_EDIT
  } slmenu_state_type;

  // Timing
  localparam longint unsigned CLK_HZ = 125000000;
  localparam longint unsigned TIMEOUT_S = 30;
  localparam longint unsigned TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
  localparam longint unsigned FLASH_HZ = 1;
  localparam longint unsigned FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);

endpackage

// [common/slmenu_key_if.sv]
// Interface carrying decoded panel key events to the menu engine
`timescale 1ns/1ps
interface slmenu_key_if;
  logic key_plus;
  logic key_minus;
  logic key_select;
  logic key_esc;
  logic card_select;
  logic any_key;
  modport src (output key_plus, key_minus, key_select, key_esc, card_select, any_key);
  modport dst (input key_plus, key_minus, key_select, key_esc, card_select, any_key);
endinterface

// [logic/slmenu_session.sv]
// Local menu session engine: select, edit, commit, cancel and inactivity timeout
`timescale 1ns/1ps
module slmenu_session #(
  parameter longint unsigned TIMEOUT_CYC = slmenu_pkg::TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Key events
  slmenu_key_if.dst keys,
  // Menu position inside the parameter list
  input wire logic [0:0] param_idx,
  // Results
  output logic session,
  output logic in_edit,
  output logic in_params,
  output logic [slmenu_pkg::PARAM_W-1:0] params,
  output logic timed_out
);

  slmenu_pkg::slmenu_state_type st_r, st_nxt;
  logic [slmenu_pkg::PARAM_W-1:0] prm_r, prm_nxt;
  logic [slmenu_pkg::PARAM_W-1:0] edit_r, edit_nxt;
  logic [37:0] tmr_r, tmr_nxt;
  logic to_r, to_nxt;
  logic expire;

  assign expire = (st_r != slmenu_pkg::MS_IDLE) && (tmr_r == 38'(TIMEOUT_CYC - 1));

  // Next state of session, parameters and timer
  always_comb begin
    st_nxt = st_r;
    prm_nxt = prm_r;
    edit_nxt = edit_r;
    tmr_nxt = tmr_r + 38'h1;
    to_nxt = 1'b0;
    if (keys.any_key) begin
      tmr_nxt = 38'h0;
    end
    unique case (st_r)
      slmenu_pkg::MS_IDLE: begin
        tmr_nxt = 38'h0;
        if (keys.card_select) begin
          st_nxt = slmenu_pkg::MS_STATUS;
        end
      end
      slmenu_pkg::MS_STATUS: begin
        if (keys.key_select || keys.key_plus) begin
          st_nxt = slmenu_pkg::MS_PARAM;
        end
      end
      slmenu_pkg::MS_PARAM: begin
        if (keys.key_select) begin
          st_nxt = slmenu_pkg::MS_EDIT;
          edit_nxt = prm_r;
        end else if (keys.key_esc) begin
          st_nxt = slmenu_pkg::MS_STATUS;
        end
      end
      slmenu_pkg::MS_EDIT: begin
        if (keys.key_plus || keys.key_minus) begin
          edit_nxt[param_idx] = ~edit_r[param_idx];
        end
        if (keys.key_select) begin
          prm_nxt = edit_r;
          st_nxt = slmenu_pkg::MS_PARAM;
        end else if (keys.key_esc) begin
          edit_nxt = prm_r;
          st_nxt = slmenu_pkg::MS_PARAM;
        end
      end
    endcase
    // Top level escape keeps the session; card select or the inactivity timeout closes it
    if (st_r != slmenu_pkg::MS_IDLE && keys.card_select) begin
      st_nxt = slmenu_pkg::MS_IDLE;
      tmr_nxt = 38'h0;
      if (st_r == slmenu_pkg::MS_EDIT) begin
        prm_nxt = edit_r;
      end
    end else if (expire && !keys.any_key) begin
      st_nxt = slmenu_pkg::MS_IDLE;
      tmr_nxt = 38'h0;
      to_nxt = 1'b1;
      if (st_r == slmenu_pkg::MS_EDIT) begin
        prm_nxt = edit_r;
      end
    end
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= slmenu_pkg::MS_IDLE;
      prm_r <= slmenu_pkg::PARAM_DEFAULT;
      edit_r <= slmenu_pkg::PARAM_DEFAULT;
      tmr_r <= 38'h0;
      to_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      prm_r <= prm_nxt;
      edit_r <= edit_nxt;
      tmr_r <= tmr_nxt;
      to_r <= to_nxt;
    end
  end

  assign session = (st_r != slmenu_pkg::MS_IDLE);
  assign in_edit = (st_r == slmenu_pkg::MS_EDIT);
  assign in_params = (st_r == slmenu_pkg::MS_PARAM) || (st_r == slmenu_pkg::MS_EDIT);
  assign params = (st_r == slmenu_pkg::MS_EDIT) ? edit_r : prm_r;
  assign timed_out = to_r;

endmodule

// [test/slmenu_panel.sv]
// Frame controller panel model routing bench presses to the card as key pulses
`timescale 1ns/1ps
module slmenu_panel (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Presses: 0 plus, 1 minus, 2 select, 3 escape
  input wire logic [3:0] press,
  // Key pulses to the card
  output logic key_plus,
  output logic key_minus,
  output logic key_select,
  output logic key_esc
);
  logic [3:0] keys_r;
  logic [3:0] keys_nxt;
  // Each press is registered and routed one cycle later, for as long as it is held
  always_comb begin
    keys_nxt = press;
  end
  // Key register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      keys_r <= 4'h0;
    end else begin
      keys_r <= keys_nxt;
    end
  end
  assign {key_esc, key_select, key_minus, key_plus} = keys_r;
endmodule

// [test/slmenu_assertions.sv]
// Concurrent checks on the status indicator and session request ports
`timescale 1ns/1ps
module slmenu_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Observed ports
  input wire logic [6:0] cond_in,
  input wire logic booting,
  input wire logic card_select_btn,
  input wire logic [2:0] led_rgb_level,
  input wire logic led_on,
  input wire logic session_req,
  input wire logic gpi_alarm
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Session request follows the card button by one cycle
  AST_REQ_PULSE: assert property (card_select_btn |=> session_req)
    else $error("no session request after card select");
  AST_REQ_ONLY: assert property (!card_select_btn |=> !session_req)
    else $error("session request without card select");
  // Indicator levels and GPI alarm
  AST_STEADY: assert property ((led_rgb_level < 3'h3)[*2] |-> led_on)
    else $error("steady level not lit");
  AST_FLASH_HOLD: assert property ($changed(led_on) && led_rgb_level >= 3'h3 &&
    $past(led_rgb_level) >= 3'h3 |=> (led_rgb_level < 3'h3 || $stable(led_on))[*3])
    else $error("flash phase too short");
  AST_BOOT_FLASH: assert property ((booting && cond_in == 7'h00)[*3] |->
    led_rgb_level == 3'h3)
    else $error("boot not flashing yellow");
  AST_IDLE_GREEN: assert property ((!booting && cond_in == 7'h00)[*3] |->
    (led_rgb_level == 3'h0 || led_rgb_level == 3'h3))
    else $error("error level without a condition");
  AST_REAR_TOP: assert property (cond_in[4][*3] |-> led_rgb_level == 3'h4)
    else $error("missing rear not flashing red");
  AST_GPI_QUIET: assert property ((cond_in == 7'h00)[*2] |-> !gpi_alarm)
    else $error("gpi alarm without a condition");
  // Main scenarios reached
  cover property (session_req);
  cover property (led_rgb_level == 3'h4 && !led_on);
  cover property (gpi_alarm);
endmodule

bind slmenu_top slmenu_assertions i_slmenu_assertions (.hclk, .hresetn, .cond_in, .booting,
  .card_select_btn, .led_rgb_level, .led_on, .session_req, .gpi_alarm);

// [test/slmenu_top_tb.sv]
// Self-checking bench for the status indicator and local menu block
`timescale 1ns/1ps
module slmenu_top_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, booting = 0, card_select_btn = 0;
  logic param_idx = 0, hreadyout, hresp, led_on, session_req, gpi_alarm, opt_tx_on, reclock_on;
  logic key_plus, key_minus, key_select, key_esc;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, cfg, gpi, seed = 32'h927e86dd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, led_rgb_level;
  logic [6:0] cond_in = 0;
  logic [3:0] press = 0;
  int failures = 0, checks_done = 0;
  // Clock of 8 ns
  always #4 hclk = ~hclk;
  slmenu_panel i_slmenu_panel (.hclk, .hresetn, .press, .key_plus, .key_minus, .key_select,
    .key_esc);
  slmenu_top #(.TIMEOUT_CYC(50), .FLASH_HALF_CYC(4)) i_slmenu_top (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .cond_in, .booting, .card_select_btn, .key_plus, .key_minus, .key_select, .key_esc,
    .param_idx, .led_rgb_level, .led_on, .session_req, .gpi_alarm, .opt_tx_on, .reclock_on);
  // Comparison with report
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Single AHB-Lite transfer, read data left in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Press 0 plus, 1 minus, 2 select, 3 escape, 4 card select
  task automatic key(input int k);
    @(posedge hclk);
    if (k == 4) begin
      card_select_btn <= 1;
    end else begin
      press <= 4'h1 << k;
    end
    @(posedge hclk);
    card_select_btn <= 0;
    press <= 0;
    repeat (4) @(posedge hclk);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction
  // Level one condition produces under a configuration word
  function automatic logic [2:0] lvl_of(input int i, input logic [31:0] c);
    logic [2:0] v;
    v = c[3*i+:3];
    if (i == 1 || i == 6) return 3'h1;
    if (i == 4) return 3'h4;
    return (v <= 3'h4 && slmenu_pkg::ALLOW_CFG[v]) ? v : 3'h0;
  endfunction
  // Most severe level among active conditions and boot
  function automatic logic [2:0] exp_led(input logic [6:0] c, input logic [31:0] g, input logic b);
    logic [2:0] m;
    m = b ? 3'h3 : 3'h0;
    for (int i = 0; i < 7; i++) if (c[i] && lvl_of(i, g) > m) m = lvl_of(i, g);
    return m;
  endfunction
  task automatic print_verdict;
    $display("Checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    print_verdict;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    cfg = {11'h0, slmenu_pkg::DEF_FW_UPDATE, slmenu_pkg::DEF_TEMP, slmenu_pkg::DEF_NO_REAR,
      slmenu_pkg::DEF_MISMATCH, slmenu_pkg::DEF_NO_MODULE, slmenu_pkg::DEF_NO_LOCK,
      slmenu_pkg::DEF_NO_SIGNAL};
    bus(0, slmenu_pkg::REG_LEVEL_CFG, 0);
    chk("level cfg", rd, cfg);
    bus(0, slmenu_pkg::REG_GPI_CFG, 0);
    chk("gpi cfg", rd, 0);
    bus(0, slmenu_pkg::REG_PARAM, 0);
    chk("params", rd, {30'h0, slmenu_pkg::PARAM_DEFAULT});
    bus(0, 8'h10, 0);
    chk("unmapped", rd, 0);
    for (int i = 0; i < 7; i++) begin
      cond_in <= 7'h1 << i;
      repeat (3) @(posedge hclk);
      chk("default level", led_rgb_level, exp_led(7'h1 << i, cfg, 0));
    end
    $display("Test defaults done");
    for (int n = 0; n < 12; n++) begin
      seed = lfsr(seed);
      cfg = (n == 0) ? 32'hffffffff : (n == 1) ? 32'h0 : seed;
      bus(1, slmenu_pkg::REG_LEVEL_CFG, cfg);
      seed = lfsr(seed);
      gpi = seed;
      bus(1, slmenu_pkg::REG_GPI_CFG, gpi);
      seed = lfsr(seed);
      cond_in <= seed[6:0];
      booting <= seed[7];
      repeat (3) @(posedge hclk);
      chk("led level", led_rgb_level, exp_led(seed[6:0], cfg, seed[7]));
      chk("gpi", gpi_alarm, |(seed[6:0] & gpi[6:0]));
    end
    cond_in <= 0;
    booting <= 0;
    $display("Test levels done");
    key(4);
    bus(0, slmenu_pkg::REG_STATUS, 0);
    chk("open", rd[2:0], 3'h1);
    chk("local flash", led_rgb_level, 3'h3);
    key(3);
    bus(0, slmenu_pkg::REG_STATUS, 0);
    chk("top escape", rd[2:0], 3'h1);
    key(0);
    key(2);
    key(0);
    chk("edit shown", opt_tx_on, 0);
    key(3);
    bus(0, slmenu_pkg::REG_STATUS, 0);
    chk("reverted", {rd[2:0], opt_tx_on}, 4'hb);
    key(2);
    key(1);
    key(2);
    param_idx <= 1;
    key(2);
    key(0);
    key(2);
    chk("committed", {opt_tx_on, reclock_on}, 2'h0);
    key(3);
    bus(0, slmenu_pkg::REG_STATUS, 0);
    chk("up a level", rd[2:0], 3'h1);
    key(0);
    key(2);
    key(0);
    repeat (30) @(posedge hclk);
    bus(0, slmenu_pkg::REG_STATUS, 0);
    chk("still open", rd[2:0], 3'h7);
    repeat (30) @(posedge hclk);
    bus(0, slmenu_pkg::REG_STATUS, 0);
    chk("timed out", {rd[2:0], led_rgb_level}, 6'h0);
    chk("timeout commit", reclock_on, 1);
    key(4);
    key(0);
    key(4);
    bus(0, slmenu_pkg::REG_STATUS, 0);
    chk("closed", rd[2:0], 3'h0);
    $display("Test session done");
    print_verdict;
  end
endmodule
